// ---- branch_clear_pkg.sv ----
// constants, opcodes and state types shared by the conditional branch logic
// assumes one core clock split into four phases per instruction cycle
package branch_clear_pkg;
  localparam int PC_W = 21;              // program counter width
  localparam int INSN_W = 16;            // instruction word width
  localparam int OFS_W = 8;              // signed offset field width
  localparam int OPC_MSB = 15;           // upper opcode byte position
  localparam int OPC_LSB = 8;
  localparam int PHASES = 4;             // clocks per instruction cycle
  localparam logic [7:0] OPC_IF_NEG_CLEAR = 8'he7;
  localparam logic [7:0] OPC_IF_OVF_CLEAR = 8'he5;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [OFS_W-1:0] OFS_RESET = 8'h00;
  localparam logic [7:0] OPC_RESET = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE, S_LIT, S_PROC, S_WRITE, S_FLUSH
  } br_state_t;

  // sign-extend the offset and double it, in program counter width
  function automatic logic [PC_W-1:0] ext_double(input logic [OFS_W-1:0] n);
    ext_double = {{(PC_W-OFS_W-1){n[OFS_W-1]}}, n, 1'b0};
  endfunction
endpackage

// ---- qphase_if.sv ----
// phase enables travelling from the phase divider to the branch logic
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface qphase_if;
  logic [3:0] q; // one-hot, bit 0 is the first phase
  modport src (output q);
  modport dst (input q);
endinterface // qphase_if

// ---- qphase_div.sv ----
// four-phase divider: one-cycle enables for each quarter of an instruction
// assumes one core clock and an asynchronous active-low reset
`timescale 1ns/100ps
module qphase_div
  import branch_clear_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // phase enables
  qphase_if.src phase
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [3:0] q;
  } div_t;
  div_t r;
  div_t next_r;

  // count phases; the enable is registered, so it trails cnt by one count
  always_comb begin
    next_r = r;
    next_r.cnt = r.cnt + 2'h1;
    next_r.q = 4'h1 << r.cnt;
  end

  // register the divider state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{cnt: PHASE_RESET, q: 4'h0};
    end else begin
      r <= next_r;
    end
  end

  assign phase.q = r.q;

  AST_ONE_HOT: assert property (@(posedge clock) disable iff (!rst_n)
    (r.q != 4'h0) |-> $onehot(r.q))
    else $error("phase enables not one-hot");
endmodule // qphase_div

// ---- branch_on_clear_flag_exec.sv ----
// execution of the two branch-on-clear-flag instructions of the core
// assumes the decoder offers an instruction at the first phase, the
// program counter input already points past the branch, and the flags
// come from logic on the same clock
`timescale 1ns/100ps
module branch_on_clear_flag_exec
  import branch_clear_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // instruction from the decoder
  input wire logic [INSN_W-1:0] insn,
  input wire logic insn_valid,
  // program counter and status flags
  input wire logic [PC_W-1:0] pc_next,
  input wire logic flag_negative,
  input wire logic flag_overflow,
  // program counter update and cycle status
  output logic pc_load,
  output logic [PC_W-1:0] pc_target,
  output logic branch_taken,
  output logic nop_cycle,
  output logic insn_retire,
  output logic [1:0] phase_now
);
  typedef struct packed {
    br_state_t st;
    logic [7:0] opc;
    logic [OFS_W-1:0] ofs;
    logic [PC_W-1:0] target;
    logic taken;
    logic pc_load;
    logic branch_taken;
    logic nop_cycle;
    logic insn_retire;
    logic [1:0] phase_now;
  } exec_t;

  exec_t r;
  exec_t next_r;
  qphase_if ph ();
  logic [7:0] insn_opc;
  logic cond_clear;

  qphase_div u_div (
    .clock(clock),
    .rst_n(rst_n),
    .phase(ph.src)
  );

  // opcode byte; the offset byte is taken straight from insn
  assign insn_opc = insn[OPC_MSB:OPC_LSB];

  // the flag tested depends on the latched opcode
  // any other opcode leaves cond_clear low, so nothing is taken
  always_comb begin
    cond_clear = 1'b0;
    if (r.opc == OPC_IF_NEG_CLEAR) begin
      cond_clear = !flag_negative;
    end else if (r.opc == OPC_IF_OVF_CLEAR) begin
      cond_clear = !flag_overflow;
    end
  end

  // one step per phase; nothing here writes a status flag
  always_comb begin
    next_r = r;
    next_r.pc_load = 1'b0;
    next_r.insn_retire = 1'b0;
    if (ph.q[0]) next_r.phase_now = 2'h0;
    if (ph.q[1]) next_r.phase_now = 2'h1;
    if (ph.q[2]) next_r.phase_now = 2'h2;
    if (ph.q[3]) next_r.phase_now = 2'h3;
    case (r.st)
      // decode: only our two opcodes are claimed
      S_IDLE: begin
        next_r.branch_taken = 1'b0;
        if (ph.q[0] && insn_valid &&
            (insn_opc == OPC_IF_NEG_CLEAR ||
             insn_opc == OPC_IF_OVF_CLEAR)) begin
          next_r.opc = insn_opc;
          next_r.ofs = insn[OFS_W-1:0];
          next_r.st = S_LIT;
        end
      end
      // read literal
      S_LIT: begin
        if (ph.q[1]) next_r.st = S_PROC;
      end
      // process: flags and base sampled together
      S_PROC: begin
        if (ph.q[2]) begin
          next_r.taken = cond_clear;
          next_r.target = pc_next + ext_double(r.ofs);
          next_r.st = S_WRITE;
        end
      end
      // write to the counter only when taken
      S_WRITE: begin
        if (ph.q[3]) begin
          if (r.taken) begin
            next_r.pc_load = 1'b1;
            next_r.branch_taken = 1'b1;
            next_r.nop_cycle = 1'b1;
            next_r.st = S_FLUSH;
          end else begin
            next_r.insn_retire = 1'b1;
            next_r.st = S_IDLE;
          end
        end
      end
      // whole idle cycle; the fetched word is ignored meanwhile, because
      // the fetch already in the pipe belongs to the abandoned path
      S_FLUSH: begin
        if (ph.q[3]) begin
          next_r.nop_cycle = 1'b0;
          next_r.insn_retire = 1'b1;
          next_r.st = S_IDLE;
        end
      end
      default: next_r.st = S_IDLE;
    endcase
  end

  // register all state
  // reset puts every output low at once, no clock edge needed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: S_IDLE, opc: OPC_RESET, ofs: OFS_RESET, target: PC_RESET,
             taken: 1'b0, pc_load: 1'b0, branch_taken: 1'b0,
             nop_cycle: 1'b0, insn_retire: 1'b0, phase_now: PHASE_RESET};
    end else begin
      r <= next_r;
    end
  end

  // outputs all come from the state register
  assign pc_load = r.pc_load;
  assign pc_target = r.target;
  assign branch_taken = r.branch_taken;
  assign nop_cycle = r.nop_cycle;
  assign insn_retire = r.insn_retire;
  assign phase_now = r.phase_now;

  // all checks run on the core clock and rest while reset is low
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_NEG_CLEAR_TAKEN: assert property (
    (r.st == S_PROC && ph.q[2] && r.opc == OPC_IF_NEG_CLEAR &&
     !flag_negative) |-> ##2 pc_load)
    else $error("negative clear did not branch");
  AST_NEG_SET_FALLS: assert property (
    (r.st == S_PROC && ph.q[2] && r.opc == OPC_IF_NEG_CLEAR &&
     flag_negative) |-> ##2 (!pc_load && insn_retire))
    else $error("negative set still branched");
  AST_OVF_CLEAR_TAKEN: assert property (
    (r.st == S_PROC && ph.q[2] && r.opc == OPC_IF_OVF_CLEAR &&
     !flag_overflow) |-> ##2 pc_load)
    else $error("overflow clear did not branch");
  AST_OVF_SET_FALLS: assert property (
    (r.st == S_PROC && ph.q[2] && r.opc == OPC_IF_OVF_CLEAR &&
     flag_overflow) |-> ##2 (!pc_load && insn_retire))
    else $error("overflow set still branched");
  AST_OFFSET_DOUBLED: assert property (
    pc_load |-> (pc_target - $past(pc_next, 2)) == ext_double(r.ofs))
    else $error("target offset not doubled sign-extended");
  AST_BASE_ADVANCED: assert property (
    pc_load |-> (pc_target - ext_double(r.ofs)) == $past(pc_next, 2))
    else $error("target base not the advanced counter");
  AST_TAKEN_TWO_CYCLES: assert property (
    pc_load |-> nop_cycle [*4] ##1 (insn_retire && !nop_cycle))
    else $error("taken branch not followed by one idle cycle");
  AST_DECODE_OPCODE: assert property (
    (r.st == S_IDLE && ph.q[0] && insn_valid &&
     insn_opc == OPC_IF_NEG_CLEAR) |=> (r.st == S_LIT &&
     r.ofs == $past(insn[OFS_W-1:0])))
    else $error("opcode e7 not claimed");

  // an offer in the no-op cycle must not disturb the branch in flight
  AST_REFUSE_IN_FLIGHT: assert property (
    (r.st == S_FLUSH && ph.q[0]) |=> (r.st == S_FLUSH && $stable(r.ofs)))
    else $error("offer accepted during the no-op cycle");
  AST_NOT_TAKEN_ONE_CYCLE: assert property (
    (r.st == S_WRITE && ph.q[3] && !r.taken) |=>
      (insn_retire && !pc_load && !nop_cycle && r.st == S_IDLE))
    else $error("not-taken branch did not retire in one cycle");
  AST_LOAD_ONE_PULSE: assert property (
    pc_load |=> !pc_load)
    else $error("counter write longer than one clock");
  AST_PHASE_LAST: assert property (
    ph.q[3] |=> (phase_now == 2'h3))
    else $error("phase index lost step with the enables");

  // decode of the second opcode and of everything else
  AST_DECODE_OVF_OPCODE: assert property (
    (r.st == S_IDLE && ph.q[0] && insn_valid &&
     insn_opc == OPC_IF_OVF_CLEAR) |=> (r.st == S_LIT &&
     r.opc == OPC_IF_OVF_CLEAR))
    else $error("opcode e5 not claimed");
  AST_OTHER_IGNORED: assert property (
    (r.st == S_IDLE && !(ph.q[0] && insn_valid &&
     (insn_opc == OPC_IF_NEG_CLEAR || insn_opc == OPC_IF_OVF_CLEAR)))
    |=> (r.st == S_IDLE))
    else $error("unclaimed word started a branch");

  // main scenarios for coverage
  COV_NEG_TAKEN: cover property (
    pc_load && r.opc == OPC_IF_NEG_CLEAR);
  COV_OVF_TAKEN: cover property (
    pc_load && r.opc == OPC_IF_OVF_CLEAR);
  COV_NOT_TAKEN: cover property (
    insn_retire && !nop_cycle && !branch_taken);
  COV_BACK_TO_BACK: cover property (
    insn_retire ##1 (r.st == S_LIT));
endmodule // branch_on_clear_flag_exec

// ---- branch_on_clear_flag_exec_tb_top.sv ----
// self-checking bench for the branch-on-clear-flag execution block
// assumes the block accepts on every fourth edge, the first being the
// second rising edge after reset release
`timescale 1ns/100ps
module branch_on_clear_flag_exec_tb_top
  import branch_clear_pkg::*;
;
  typedef struct {
    logic [7:0] opc;
    logic [7:0] ofs;
    logic neg;
    logic ovf;
    logic vld;
    logic [PC_W-1:0] pc;
    logic acc;
    logic tkn;
  } row_t;
  logic clock;
  logic rst_n;
  logic [INSN_W-1:0] insn;
  logic insn_valid;
  logic [PC_W-1:0] pc_next;
  logic flag_negative;
  logic flag_overflow;
  logic pc_load;
  logic [PC_W-1:0] pc_target;
  logic branch_taken;
  logic nop_cycle;
  logic insn_retire;
  logic [1:0] phase_now;
  int errors = 0;
  int checked = 0;
  int cnt;
  // ordinary cases; offset extremes and counter wrap included
  row_t rows [8] = '{
    '{8'he7, 8'h05, 1'b0, 1'b1, 1'b1, 21'h000100, 1'b1, 1'b1},
    '{8'he7, 8'h80, 1'b1, 1'b0, 1'b1, 21'h000100, 1'b1, 1'b0},
    '{8'he5, 8'hff, 1'b1, 1'b0, 1'b1, 21'h000010, 1'b1, 1'b1},
    '{8'he5, 8'h7f, 1'b0, 1'b1, 1'b1, 21'h000010, 1'b1, 1'b0},
    '{8'he6, 8'h01, 1'b0, 1'b0, 1'b1, 21'h000020, 1'b0, 1'b0},
    '{8'he7, 8'h01, 1'b0, 1'b0, 1'b0, 21'h000020, 1'b0, 1'b0},
    '{8'he7, 8'h80, 1'b0, 1'b0, 1'b1, 21'h000000, 1'b1, 1'b1},
    '{8'he5, 8'h7f, 1'b1, 1'b0, 1'b1, 21'h1ffff0, 1'b1, 1'b1}
  };

  branch_on_clear_flag_exec DUT (
    .clock(clock),
    .rst_n(rst_n),
    .insn(insn),
    .insn_valid(insn_valid),
    .pc_next(pc_next),
    .flag_negative(flag_negative),
    .flag_overflow(flag_overflow),
    .pc_load(pc_load),
    .pc_target(pc_target),
    .branch_taken(branch_taken),
    .nop_cycle(nop_cycle),
    .insn_retire(insn_retire),
    .phase_now(phase_now)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // edges since release; phase-0 edges are 2, 6, 10 ...
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) cnt <= 0;
    else cnt <= cnt + 1;
  end

  task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // insn_valid stays up through a taken flow, so the phase-0 offer
  // during the no-op cycle must be ignored
  task automatic run(input row_t r);
    logic [PC_W-1:0] exp_t;
    exp_t = r.pc + {{12{r.ofs[7]}}, r.ofs, 1'b0};
    while (cnt % 4 != 1) @(negedge clock);
    insn = {r.opc, r.ofs};
    insn_valid = r.vld;
    flag_negative = r.neg;
    flag_overflow = r.ovf;
    pc_next = r.pc;
    repeat (4) @(negedge clock);
    chk(pc_load, r.tkn);
    chk(insn_retire, r.acc & !r.tkn);
    chk(branch_taken, r.tkn);
    chk(phase_now, 2'h3);
    if (r.acc) chk(pc_target, exp_t);
    if (r.tkn) begin
      chk(nop_cycle, 1'b1);
      repeat (3) @(negedge clock);
      chk(nop_cycle, 1'b1);
      @(negedge clock);
      chk(insn_retire, 1'b1);
      chk(nop_cycle, 1'b0);
      chk(pc_load, 1'b0);
    end
  endtask

  task automatic finish_test;
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // run needs well under 400 cycles
  initial begin
    #20000;
    errors++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    insn = 16'h0000;
    insn_valid = 1'b0;
    pc_next = 21'h000000;
    flag_negative = 1'b0;
    flag_overflow = 1'b0;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk(pc_load, 1'b0);
    chk(phase_now, 2'h0);
    foreach (rows[i]) run(rows[i]);
    // an offer during the no-op cycle is refused
    while (cnt % 4 != 1) @(negedge clock);
    insn = 16'he710;
    flag_negative = 1'b0;
    pc_next = 21'h000080;
    repeat (4) @(negedge clock);
    chk(pc_load, 1'b1);
    insn = 16'he503;
    flag_overflow = 1'b0;
    pc_next = 21'h000200;
    repeat (4) @(negedge clock);
    chk(pc_target, 21'h0000a0);
    chk(pc_load, 1'b0);
    chk(insn_retire, 1'b1);
    // reset in the middle of a taken branch clears pc_load, nop_cycle, branch_taken and pc_target
    while (cnt % 4 != 1) @(negedge clock);
    insn = 16'he700;
    flag_negative = 1'b0;
    pc_next = 21'h000040;
    repeat (4) @(negedge clock);
    chk(pc_load, 1'b1);
    chk(pc_target, 21'h000040);
    rst_n = 1'b0;
    insn_valid = 1'b0;
    #1;
    chk(pc_load, 1'b0);
    chk(nop_cycle, 1'b0);
    chk(branch_taken, 1'b0);
    chk(pc_target, 21'h000000);
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    run(rows[0]);
    finish_test();
  end
endmodule // branch_on_clear_flag_exec_tb_top
